// ---- logic/sensor_port_pkg.sv ----
/*
  constants, types and register map of the sensor serial host port.
  assumes one 20 MHz clock and a synchronous active-high power-on reset.
*/
package sensor_port_pkg;

  // register offsets
  localparam logic [7:0] PRES_CFG_ADDR = 8'h06;
  localparam logic [7:0] TEMP_CFG_ADDR = 8'h07;
  localparam logic [7:0] MEAS_CTRL_ADDR = 8'h08;
  localparam logic [7:0] FIFO_IF_CFG_ADDR = 8'h09;
  localparam logic [7:0] PRODUCT_ID_ADDR = 8'h0d;

  // reset value of every stored byte
  localparam logic [7:0] REG_RESET = 8'h00;

  // fields of fifo_interface_config
  localparam int SPI_3WIRE_BIT = 0;
  localparam int INT_ON_PIN_BIT = 7;

  // target addresses chosen by the serial-out strap
  localparam logic [6:0] I2C_ADDR_STRAP_HIGH = 7'h77;
  localparam logic [6:0] I2C_ADDR_STRAP_LOW = 7'h76;

  // cycles after reset release until the strap is taken
  localparam logic [1:0] STRAP_TAKE_CYCLE = 2'h2;
  localparam logic [1:0] STRAP_DONE_CYCLE = 2'h3;

  // bits in a byte on either link
  localparam logic [3:0] BYTE_BITS = 4'h8;

  typedef enum logic [1:0] {
    IF_OPEN = 2'b00,
    IF_I2C = 2'b01,
    IF_SPI = 2'b10
  } iface_t;

  typedef enum logic [3:0] {
    I_IDLE = 4'b0000,
    I_ADDR = 4'b0001,
    I_ADDR_ACK = 4'b0010,
    I_REG = 4'b0011,
    I_REG_ACK = 4'b0100,
    I_WDATA = 4'b0101,
    I_WACK = 4'b0110,
    I_RDATA = 4'b0111,
    I_RACK = 4'b1000
  } i2c_state_t;

endpackage

// ---- logic/sensor_serial_host_port.sv ----
/*
  serial host port: interface select and lock, I2C target, SPI target
  (mode 11, 3- or 4-wire), register bytes and serial-out pin sharing.
  assumes clock pin and data pin are shared by I2C and SPI, all pins are
  asynchronous to clock_in and the link runs well below 1/8 of it.
*/
module sensor_serial_host_port #(
  parameter int REG_COUNT = 64,
  parameter logic [7:0] PRODUCT_ID = 8'h5a // arbitrary value
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // host link pins
  input wire logic iface_select_pin_in,
  input wire logic ser_clk_in,
  input wire logic ser_data_in,
  output logic ser_data_out,
  output logic ser_data_oe_out,
  input wire logic serial_out_strap_pin_in,
  output logic serial_out_strap_pin_out,
  output logic serial_out_strap_pin_oe_out,
  // measurement core side
  input wire logic core_wr_en_in,
  input wire logic [7:0] core_wr_addr_in,
  input wire logic [7:0] core_wr_data_in,
  input wire logic core_int_in,
  output logic [7:0] pressure_measure_config_out,
  output logic [7:0] temperature_measure_config_out,
  output logic [7:0] measurement_control_out,
  output logic [7:0] fifo_interface_config_out,
  output sensor_port_pkg::iface_t iface_mode_out
);
  import sensor_port_pkg::*;

  localparam int AW = $clog2(REG_COUNT);
  localparam logic [8:0] REG_LIMIT = 9'(REG_COUNT);

  initial begin
    if (REG_COUNT < 16 || REG_COUNT > 256 || (1 << AW) != REG_COUNT) begin
      $error("REG_COUNT must be a power of two from 16 to 256");
    end
  end

  logic [7:0] mem [REG_COUNT];

  // byte seen by the host; product code is fixed, missing bytes read zero
  function automatic logic [7:0] rd_byte(input logic [7:0] a);
    if (a == PRODUCT_ID_ADDR) begin
      return PRODUCT_ID;
    end
    if ({1'b0, a} < REG_LIMIT) begin
      return mem[a[AW-1:0]];
    end
    return 8'h00;
  endfunction

  // only the four configuration bytes take host writes
  function automatic logic host_writable(input logic [7:0] a);
    return a >= PRES_CFG_ADDR && a <= FIFO_IF_CFG_ADDR;
  endfunction

  // pin synchronisers: bit0 clock, bit1 data, bit2 select, bit3 strap
  logic [3:0] sync1_q, sync2_q, prev_q;
  logic clk_s, dat_s, sel_s, clk_rise, clk_fall, start_ev, stop_ev;
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      sync1_q <= 4'hf;
      sync2_q <= 4'hf;
      prev_q <= 4'hf;
    end else begin
      sync1_q <= {serial_out_strap_pin_in, iface_select_pin_in, ser_data_in, ser_clk_in};
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end
  assign clk_s = sync2_q[0];
  assign dat_s = sync2_q[1];
  assign sel_s = sync2_q[2];
  assign clk_rise = clk_s && !prev_q[0];
  assign clk_fall = !clk_s && prev_q[0];
  // start and stop are data edges while the clock stays high
  assign start_ev = clk_s && prev_q[0] && !dat_s && prev_q[1];
  assign stop_ev = clk_s && prev_q[0] && dat_s && !prev_q[1];

  // interface lock and strap capture
  iface_t iface_q, iface_d;
  logic [1:0] strap_cnt_q, strap_cnt_d;
  logic strap_q, strap_d, int_q;
  logic i_match;
  logic [6:0] dev_addr;
  always_comb begin
    iface_d = iface_q;
    strap_cnt_d = strap_cnt_q;
    strap_d = strap_q;
    if (iface_q == IF_OPEN) begin
      if (!sel_s) begin
        iface_d = IF_SPI;
      end else if (i_match) begin
        iface_d = IF_I2C;
      end
    end
    // strap is taken once the synchroniser holds the real level
    if (strap_cnt_q != STRAP_DONE_CYCLE) begin
      strap_cnt_d = strap_cnt_q + 2'h1;
      if (strap_cnt_q == STRAP_TAKE_CYCLE) begin
        strap_d = sync2_q[3];
      end
    end
  end
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      iface_q <= IF_OPEN;
      strap_cnt_q <= 2'h0;
      strap_q <= 1'b1;
      int_q <= 1'b0;
    end else begin
      iface_q <= iface_d;
      strap_cnt_q <= strap_cnt_d;
      strap_q <= strap_d;
      int_q <= core_int_in;
    end
  end
  assign dev_addr = strap_q ? I2C_ADDR_STRAP_HIGH : I2C_ADDR_STRAP_LOW;

  // I2C target; oversampled edges serve every bus rate the clock allows
  i2c_state_t i_st_q, i_st_d;
  logic [3:0] i_cnt_q, i_cnt_d;
  logic [7:0] i_sh_q, i_sh_d, i_ptr_q, i_ptr_d, rd_i;
  logic i_oe_q, i_oe_d, i_rw_q, i_rw_d, i_ack_q, i_ack_d, i_wr;
  assign rd_i = rd_byte(i_ptr_q);
  always_comb begin
    i_st_d = i_st_q;
    i_cnt_d = i_cnt_q;
    i_sh_d = i_sh_q;
    i_ptr_d = i_ptr_q;
    i_oe_d = i_oe_q;
    i_rw_d = i_rw_q;
    i_ack_d = i_ack_q;
    i_wr = 1'b0;
    i_match = 1'b0;
    if (start_ev) begin
      i_st_d = I_ADDR; // repeated start keeps the pointer
      i_cnt_d = 4'h0;
      i_oe_d = 1'b0;
    end else if (stop_ev) begin
      i_st_d = I_IDLE;
      i_oe_d = 1'b0;
    end else begin
      unique case (i_st_q)
        I_IDLE: begin
          i_oe_d = 1'b0;
        end
        I_ADDR, I_REG, I_WDATA: begin
          if (clk_rise) begin
            i_sh_d = {i_sh_q[6:0], dat_s};
            i_cnt_d = i_cnt_q + 4'h1;
          end else if (clk_fall && i_cnt_q == BYTE_BITS) begin
            i_cnt_d = 4'h0;
            if (i_st_q == I_ADDR) begin
              // a select pin already low shuts the I2C target out
              if (i_sh_q[7:1] == dev_addr && iface_q != IF_SPI && sel_s) begin
                i_match = 1'b1;
                i_oe_d = 1'b1;
                i_rw_d = i_sh_q[0];
                i_st_d = I_ADDR_ACK;
              end else begin
                i_st_d = I_IDLE;
              end
            end else if (i_st_q == I_REG) begin
              i_ptr_d = i_sh_q;
              i_oe_d = 1'b1;
              i_st_d = I_REG_ACK;
            end else begin
              i_wr = 1'b1;
              i_ptr_d = i_ptr_q + 8'h01;
              i_oe_d = 1'b1;
              i_st_d = I_WACK;
            end
          end
        end
        I_ADDR_ACK, I_REG_ACK, I_WACK: begin
          if (clk_fall) begin
            if (i_st_q == I_ADDR_ACK && i_rw_q) begin
              i_sh_d = rd_i;
              i_oe_d = ~rd_i[7];
              i_st_d = I_RDATA;
            end else begin
              i_oe_d = 1'b0;
              i_st_d = (i_st_q == I_ADDR_ACK) ? I_REG : I_WDATA;
            end
          end
        end
        I_RDATA: begin
          if (clk_fall) begin
            if (i_cnt_q == 4'h7) begin
              i_oe_d = 1'b0;
              i_cnt_d = 4'h0;
              i_ptr_d = i_ptr_q + 8'h01;
              i_st_d = I_RACK;
            end else begin
              i_sh_d = {i_sh_q[6:0], 1'b0};
              i_oe_d = ~i_sh_q[6];
              i_cnt_d = i_cnt_q + 4'h1;
            end
          end
        end
        I_RACK: begin
          if (clk_rise) begin
            i_ack_d = ~dat_s;
          end else if (clk_fall) begin
            if (i_ack_q) begin
              i_sh_d = rd_i;
              i_oe_d = ~rd_i[7];
              i_st_d = I_RDATA;
            end else begin
              i_st_d = I_IDLE;
            end
          end
        end
        default: begin
          i_st_d = I_IDLE;
          i_oe_d = 1'b0;
        end
      endcase
    end
  end
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      i_st_q <= I_IDLE;
      i_cnt_q <= 4'h0;
      i_sh_q <= 8'h00;
      i_ptr_q <= 8'h00;
      i_oe_q <= 1'b0;
      i_rw_q <= 1'b0;
      i_ack_q <= 1'b0;
    end else begin
      i_st_q <= i_st_d;
      i_cnt_q <= i_cnt_d;
      i_sh_q <= i_sh_d;
      i_ptr_q <= i_ptr_d;
      i_oe_q <= i_oe_d;
      i_rw_q <= i_rw_d;
      i_ack_q <= i_ack_d;
    end
  end

  // SPI target, mode 11: sample on rise, shift out on fall
  logic spi_act, three_wire, s_wr;
  logic [2:0] s_cnt_q, s_cnt_d, s_obit_q, s_obit_d;
  logic [7:0] s_in_q, s_in_d, s_sh_q, s_sh_d, s_ptr_q, s_ptr_d, byte_in, rd_s;
  logic s_cmd_q, s_cmd_d, s_rd_q, s_rd_d, s_done_q, s_done_d;
  logic s_out_q, s_out_d, s_drv_q, s_drv_d;
  assign spi_act = iface_q == IF_SPI && !sel_s;
  assign three_wire = mem[FIFO_IF_CFG_ADDR[AW-1:0]][SPI_3WIRE_BIT];
  assign byte_in = {s_in_q[6:0], dat_s};
  assign rd_s = rd_byte(spi_act && s_cmd_q ? {1'b0, byte_in[6:0]} : s_ptr_q);
  always_comb begin
    s_cnt_d = s_cnt_q;
    s_obit_d = s_obit_q;
    s_in_d = s_in_q;
    s_sh_d = s_sh_q;
    s_ptr_d = s_ptr_q;
    s_cmd_d = s_cmd_q;
    s_rd_d = s_rd_q;
    s_done_d = s_done_q;
    s_out_d = s_out_q;
    s_drv_d = s_drv_q;
    s_wr = 1'b0;
    if (!spi_act) begin
      // frame ends with the select pin
      s_cnt_d = 3'h0;
      s_obit_d = 3'h0;
      s_cmd_d = 1'b1;
      s_rd_d = 1'b0;
      s_done_d = 1'b0;
      s_drv_d = 1'b0;
    end else if (clk_rise) begin
      s_in_d = byte_in;
      s_cnt_d = s_cnt_q + 3'h1;
      if (s_cnt_q == 3'h7) begin
        if (s_cmd_q) begin
          s_cmd_d = 1'b0;
          s_rd_d = byte_in[7];
          s_ptr_d = {1'b0, byte_in[6:0]};
          if (byte_in[7]) begin
            s_sh_d = rd_s;
            s_ptr_d = {1'b0, byte_in[6:0]} + 8'h01;
            s_obit_d = 3'h0;
          end
        end else if (!s_rd_q && !s_done_q) begin
          s_wr = 1'b1;
          s_done_d = 1'b1; // later bytes are dropped
        end
      end
    end else if (clk_fall && s_rd_q) begin
      s_out_d = s_sh_q[7];
      s_drv_d = 1'b1;
      s_obit_d = s_obit_q + 3'h1;
      if (s_obit_q == 3'h7) begin
        s_sh_d = rd_s;
        s_ptr_d = s_ptr_q + 8'h01;
      end else begin
        s_sh_d = {s_sh_q[6:0], 1'b0};
      end
    end
  end
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      s_cnt_q <= 3'h0;
      s_obit_q <= 3'h0;
      s_in_q <= 8'h00;
      s_sh_q <= 8'h00;
      s_ptr_q <= 8'h00;
      s_cmd_q <= 1'b1;
      s_rd_q <= 1'b0;
      s_done_q <= 1'b0;
      s_out_q <= 1'b1;
      s_drv_q <= 1'b0;
    end else begin
      s_cnt_q <= s_cnt_d;
      s_obit_q <= s_obit_d;
      s_in_q <= s_in_d;
      s_sh_q <= s_sh_d;
      s_ptr_q <= s_ptr_d;
      s_cmd_q <= s_cmd_d;
      s_rd_q <= s_rd_d;
      s_done_q <= s_done_d;
      s_out_q <= s_out_d;
      s_drv_q <= s_drv_d;
    end
  end

  // register byte writes; host wins over the core on a clash
  logic m_we;
  logic [7:0] m_addr, m_data;
  always_comb begin
    m_we = core_wr_en_in;
    m_addr = core_wr_addr_in;
    m_data = core_wr_data_in;
    if (i_wr && host_writable(i_ptr_q)) begin
      m_we = 1'b1;
      m_addr = i_ptr_q;
      m_data = i_sh_q;
    end else if (s_wr && host_writable(s_ptr_q)) begin
      m_we = 1'b1;
      m_addr = s_ptr_q;
      m_data = byte_in;
    end
  end
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      for (int k = 0; k < REG_COUNT; k++) begin
        mem[k] <= REG_RESET;
      end
    end else if (m_we && {1'b0, m_addr} < REG_LIMIT) begin
      mem[m_addr[AW-1:0]] <= m_data;
    end
  end

  // pin drive: SPI 4-wire owns the serial-out pin, else it may carry the interrupt
  logic spi4_drive;
  assign spi4_drive = spi_act && !three_wire && s_drv_q && s_rd_q;
  assign ser_data_out = (iface_q == IF_SPI) ? s_out_q : 1'b0;
  assign ser_data_oe_out = i_oe_q || (spi_act && three_wire && s_drv_q && s_rd_q);
  assign serial_out_strap_pin_out = spi4_drive ? s_out_q : int_q;
  assign serial_out_strap_pin_oe_out = spi4_drive || (!(iface_q == IF_SPI && !three_wire)
      && strap_cnt_q == STRAP_DONE_CYCLE && fifo_interface_config_out[INT_ON_PIN_BIT]);
  assign pressure_measure_config_out = mem[PRES_CFG_ADDR[AW-1:0]];
  assign temperature_measure_config_out = mem[TEMP_CFG_ADDR[AW-1:0]];
  assign measurement_control_out = mem[MEAS_CTRL_ADDR[AW-1:0]];
  assign fifo_interface_config_out = mem[FIFO_IF_CFG_ADDR[AW-1:0]];
  assign iface_mode_out = iface_q;

  // checks on lock, addressing and transfer behaviour
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  select_low_a: assert property (iface_q == IF_OPEN && !sel_s |=> iface_q == IF_SPI)
    else $error("low select did not pick SPI");
  spi_lock_a: assert property (iface_q == IF_SPI |=> iface_q == IF_SPI [*8])
    else $error("SPI lock released");
  i2c_lock_a: assert property (i_match && iface_q == IF_OPEN |=> iface_q == IF_I2C ##1 iface_q == IF_I2C)
    else $error("I2C access did not lock interface");
  addr_ack_a: assert property (i_match |=> i_oe_q && i_st_q == I_ADDR_ACK)
    else $error("matched address not acknowledged");
  spi4_pin_a: assert property (spi4_drive |-> serial_out_strap_pin_oe_out
      && serial_out_strap_pin_out == s_out_q && !ser_data_oe_out)
    else $error("4-wire read data not on serial-out pin");
  i2c_incr_a: assert property (i_wr |=> i_ptr_q == $past(i_ptr_q) + 8'h01)
    else $error("I2C pointer did not advance");
  spi_one_write_a: assert property (s_wr |=> (s_done_q && !s_wr) [*4])
    else $error("second SPI write in a frame");
  spi_edge_a: assert property ($changed(s_out_q) |-> $past(clk_fall))
    else $error("SPI output changed off falling edge");
  spi_mode_a: assert property (s_cnt_q != $past(s_cnt_q) && spi_act |-> $past(clk_rise))
    else $error("SPI sampled off rising edge");
  i2c_write_c: cover property (i_wr ##[1:400] stop_ev);
  i2c_read_c: cover property (i_st_q == I_RACK ##1 i_st_q == I_RDATA);
  spi_read_c: cover property (spi_act && s_rd_q && s_obit_q == 3'h7 && clk_fall);
  spi_write_c: cover property (s_wr && host_writable(s_ptr_q));

endmodule

// ---- tb/host_link_model.sv ----
/*
  host controller model: drives the select, clock and data pins as an I2C or
  SPI controller and resolves the shared data and serial-out wires.
  assumes the bench calls its tasks, and that every pin change lands 1 ns
  after a rising edge of clock_in.
*/
module host_link_model (
  // pacing clock
  input wire logic clock_in,
  // pins as seen on the wires
  output logic sel_pin_out,
  output logic clk_pin_out,
  output logic data_line_out,
  output logic so_line_out,
  // device pin drivers
  input wire logic dev_data_in,
  input wire logic dev_data_oe_in,
  input wire logic dev_so_in,
  input wire logic dev_so_oe_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic host_en = 1'b0;
  logic host_val = 1'b1;
  logic strap_lvl = 1'b1;

  // data wire has a pull-up, serial-out wire rests at the strap level; either party may pull the data line low
  assign data_line_out = (dev_data_oe_in ? dev_data_in : 1'b1) & (host_en ? host_val : 1'b1);
  assign so_line_out = dev_so_oe_in ? dev_so_in : strap_lvl;

  // idle: select high, clock idles high
  initial begin
    sel_pin_out = 1'b1;
    clk_pin_out = 1'b1;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask

  // start or repeated start: data falls while clock high
  task automatic i2c_start();
    host_en = 1'b0;
    hold(2);
    clk_pin_out = 1'b1;
    hold(4);
    host_en = 1'b1;
    host_val = 1'b0;
    hold(4);
    clk_pin_out = 1'b0;
    hold(2);
  endtask

  // open drain bit; levels held 4 cycles, well above the device's oversampling
  task automatic i2c_bit(input logic b, output logic r);
    host_en = ~b;
    host_val = 1'b0;
    hold(2);
    clk_pin_out = 1'b1;
    hold(2);
    r = data_line_out;
    hold(2);
    clk_pin_out = 1'b0;
    hold(2);
  endtask

  task automatic i2c_byte(input logic [7:0] tx, input logic ack_tx, output logic [7:0] rx,
                          output logic ack_rx);
    for (int i = 7; i >= 0; i--) i2c_bit(tx[i], rx[i]);
    i2c_bit(ack_tx, ack_rx);
  endtask

  task automatic i2c_stop();
    host_en = 1'b1;
    host_val = 1'b0;
    hold(2);
    clk_pin_out = 1'b1;
    hold(4);
    host_en = 1'b0;
    hold(4);
  endtask

  // select low before any I2C access of this run claims the device for SPI
  task automatic spi_begin();
    sel_pin_out = 1'b0;
    hold(4);
  endtask

  // mode 11 only: change on the falling edge, sample at the rise
  task automatic spi_byte(input logic [7:0] tx, input logic drive, input logic three,
                          output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      clk_pin_out = 1'b0;
      host_en = drive;
      host_val = tx[i];
      hold(4);
      clk_pin_out = 1'b1;
      rx[i] = three ? data_line_out : so_line_out;
      hold(4);
    end
  endtask

  // clock left idling high between frames
  task automatic spi_end();
    host_en = 1'b0;
    sel_pin_out = 1'b1;
    hold(8);
  endtask
endmodule

// ---- tb/sensor_serial_host_port_bench.sv ----
/*
  self-checking bench of the sensor serial host port: lock-out, I2C and SPI
  transfers, strap address and serial-out pin sharing.
  assumes the host model in host_link_model.sv and the design package.
*/
`define CHECK(got, exp) begin \
  checked++; \
  if ((got) !== (exp)) begin \
    miscompares++; \
    $display("MISMATCH at %0t got %h expected %h", $time, (got), (exp)); \
  end \
end

module sensor_serial_host_port_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import sensor_port_pkg::*;
  localparam logic [7:0] ID_VAL = 8'h3c; // arbitrary value
  logic clock_in;
  logic rst_in;
  logic core_wr_en;
  logic [7:0] core_wr_addr;
  logic [7:0] core_wr_data;
  logic core_int;
  logic sel_pin, clk_pin, data_line, so_line, dev_data, dev_data_oe, dev_so, dev_so_oe;
  logic [7:0] pres_cfg, temp_cfg, meas_ctrl, fifo_cfg;
  iface_t iface_mode;
  logic [7:0] wbuf [4];
  logic [7:0] rbuf [4];
  logic nak;
  int miscompares = 0;
  int checked = 0;

  always #25 clock_in = ~clock_in;

  sensor_serial_host_port #(.REG_COUNT(64), .PRODUCT_ID(ID_VAL)) i_dut (
    .clock_in(clock_in), .rst_in(rst_in), .iface_select_pin_in(sel_pin),
    .ser_clk_in(clk_pin), .ser_data_in(data_line), .ser_data_out(dev_data),
    .ser_data_oe_out(dev_data_oe), .serial_out_strap_pin_in(so_line),
    .serial_out_strap_pin_out(dev_so), .serial_out_strap_pin_oe_out(dev_so_oe),
    .core_wr_en_in(core_wr_en), .core_wr_addr_in(core_wr_addr),
    .core_wr_data_in(core_wr_data), .core_int_in(core_int),
    .pressure_measure_config_out(pres_cfg), .temperature_measure_config_out(temp_cfg),
    .measurement_control_out(meas_ctrl), .fifo_interface_config_out(fifo_cfg),
    .iface_mode_out(iface_mode));

  host_link_model i_host (
    .clock_in(clock_in), .sel_pin_out(sel_pin), .clk_pin_out(clk_pin),
    .data_line_out(data_line), .so_line_out(so_line), .dev_data_in(dev_data),
    .dev_data_oe_in(dev_data_oe), .dev_so_in(dev_so), .dev_so_oe_in(dev_so_oe));

  task automatic complete_run();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // strap and select must be settled before release, the strap is taken once
  task automatic do_reset(input logic strap, input logic sel);
    i_host.strap_lvl = strap;
    i_host.sel_pin_out = sel;
    rst_in = 1'b1;
    i_host.hold(10);
    rst_in = 1'b0;
    i_host.hold(6);
    `CHECK({pres_cfg, temp_cfg, meas_ctrl, fifo_cfg}, {4{REG_RESET}});
    `CHECK(iface_mode, IF_OPEN);
  endtask

  task automatic core_write(input logic [7:0] a, input logic [7:0] d);
    core_wr_en = 1'b1;
    core_wr_addr = a;
    core_wr_data = d;
    i_host.hold(1);
    core_wr_en = 1'b0;
    i_host.hold(1);
  endtask

  // stop left out when a read follows with a repeated start
  task automatic i2c_write(input logic [6:0] dev, input logic [7:0] a, input int n,
                           input bit stop = 1'b1);
    logic [7:0] rx;
    logic ack;
    i_host.i2c_start();
    i_host.i2c_byte({dev, 1'b0}, 1'b1, rx, nak);
    if (!nak) begin
      i_host.i2c_byte(a, 1'b1, rx, ack);
      for (int i = 0; i < n; i++) i_host.i2c_byte(wbuf[i], 1'b1, rx, ack);
    end
    if (stop) i_host.i2c_stop();
  endtask

  // register phase, repeated start, then n bytes, the last one refused
  task automatic i2c_read(input logic [6:0] dev, input logic [7:0] a, input int n);
    logic [7:0] rx;
    logic ack;
    i2c_write(dev, a, 0, 1'b0);
    i_host.i2c_start();
    i_host.i2c_byte({dev, 1'b1}, 1'b1, rx, ack);
    for (int i = 0; i < n; i++) begin
      i_host.i2c_byte(8'hff, i == n - 1, rx, ack);
      rbuf[i] = rx;
    end
    i_host.i2c_stop();
  endtask

  task automatic spi_frame(input logic [7:0] cmd, input int n, input logic three);
    logic [7:0] rx;
    i_host.spi_begin();
    i_host.spi_byte(cmd, 1'b1, three, rx);
    for (int i = 0; i < n; i++) begin
      if (cmd[7]) i_host.spi_byte(8'hff, 1'b0, three, rx);
      else i_host.spi_byte(wbuf[i], 1'b1, three, rx);
      rbuf[i] = rx;
    end
    i_host.spi_end();
  endtask

  // burst write and burst read over I2C, then lock-out of SPI
  task automatic test_i2c_lock();
    do_reset(1'b1, 1'b1);
    wbuf = '{8'h11, 8'h22, 8'h33, 8'h44};
    i2c_write(7'h76, PRES_CFG_ADDR, 1);
    `CHECK(nak, 1'b1);
    i2c_write(I2C_ADDR_STRAP_HIGH, PRES_CFG_ADDR, 4);
    `CHECK(nak, 1'b0);
    `CHECK(iface_mode, IF_I2C);
    `CHECK({pres_cfg, temp_cfg, meas_ctrl, fifo_cfg}, 32'h11223344);
    i2c_read(I2C_ADDR_STRAP_HIGH, PRES_CFG_ADDR, 4);
    for (int i = 0; i < 4; i++) `CHECK(rbuf[i], wbuf[i]);
    i2c_read(I2C_ADDR_STRAP_HIGH, PRODUCT_ID_ADDR, 1);
    `CHECK(rbuf[0], ID_VAL);
    wbuf[0] = 8'h55;
    spi_frame(8'h06, 1, 1'b0);
    `CHECK(pres_cfg, 8'h11);
    `CHECK(iface_mode, IF_I2C);
  endtask

  // strap tied low moves the address down by one
  task automatic test_strap_low();
    do_reset(1'b0, 1'b1);
    wbuf[0] = 8'h7e;
    i2c_write(7'h77, TEMP_CFG_ADDR, 1);
    `CHECK(nak, 1'b1);
    i2c_write(I2C_ADDR_STRAP_LOW, TEMP_CFG_ADDR, 1);
    `CHECK(nak, 1'b0);
    i2c_read(I2C_ADDR_STRAP_LOW, TEMP_CFG_ADDR, 1);
    `CHECK(rbuf[0], 8'h7e);
  endtask

  // four-wire SPI: single write drops extra bytes, burst read, I2C shut out
  task automatic test_spi_4wire();
    do_reset(1'b1, 1'b1);
    core_write(8'h20, 8'ha5);
    core_write(8'h21, 8'h5a);
    wbuf = '{8'h3c, 8'h99, 8'h00, 8'h00};
    spi_frame({1'b0, TEMP_CFG_ADDR[6:0]}, 2, 1'b0);
    `CHECK(iface_mode, IF_SPI);
    `CHECK(temp_cfg, 8'h3c);
    `CHECK(meas_ctrl, 8'h00);
    spi_frame(8'ha0, 2, 1'b0);
    `CHECK({rbuf[0], rbuf[1]}, 16'ha55a);
    i2c_write(I2C_ADDR_STRAP_HIGH, PRES_CFG_ADDR, 1);
    `CHECK(nak, 1'b1);
    `CHECK(iface_mode, IF_SPI);
  endtask

  // three-wire read on the data pin, interrupt only off the four-wire mode
  task automatic test_spi_3wire();
    wbuf[0] = 8'h81;
    spi_frame({1'b0, FIFO_IF_CFG_ADDR[6:0]}, 1, 1'b0);
    `CHECK(fifo_cfg, 8'h81);
    spi_frame({1'b1, TEMP_CFG_ADDR[6:0]}, 1, 1'b1);
    `CHECK(rbuf[0], 8'h3c);
    core_int = 1'b1;
    i_host.hold(4);
    `CHECK({dev_so_oe, dev_so}, 2'b11);
    wbuf[0] = 8'h80;
    spi_frame({1'b0, FIFO_IF_CFG_ADDR[6:0]}, 1, 1'b1);
    i_host.hold(4);
    `CHECK(dev_so_oe, 1'b0);
    spi_frame({1'b1, FIFO_IF_CFG_ADDR[6:0]}, 1, 1'b0);
    `CHECK(rbuf[0], 8'h80);
  endtask

  // main sequence; levels set before the first clock edge
  initial begin
    clock_in = 1'b0;
    rst_in = 1'b1;
    core_wr_en = 1'b0;
    core_wr_addr = 8'h00;
    core_wr_data = 8'h00;
    core_int = 1'b0;
    test_i2c_lock();
    test_strap_low();
    test_spi_4wire();
    test_spi_3wire();
    complete_run();
  end

  // watchdog: the whole run needs well under 20000 cycles
  initial begin
    repeat (40000) @(posedge clock_in);
    miscompares++;
    complete_run();
  end
endmodule
